// ==== hdl/csk_consts.svh ====
// Constants for the compare-and-skip instruction decoder
// Functional notes
// - Greater opcode skips when file byte exceeds working
// - Less opcode skips when file byte below working
// - Taken skip flushes next word, adds nop
// - Two-word skipped instruction costs three cycles
// - Bank bit picks access bank or bank_select
// - Extended set, bank clear, f<=5Fh indexes
// - Extended addressing off while config bit zero
`ifndef CSK_CONSTS_SVH
`define CSK_CONSTS_SVH
`define CSK_OPC_HI 4'h6
`define CSK_SUB_GT 3'h2
`define CSK_SUB_LT 3'h0
`define CSK_OP_HI_POS 12
`define CSK_SUB_POS 9
`define CSK_A_POS 8
`define CSK_IDX_LIMIT 8'h5F
`define CSK_ACC_LOW_LIMIT 8'h7F
`define CSK_ACC_HIGH_BANK 4'hF
`define CSK_ACC_LOW_BANK 4'h0
`define CSK_NOP_ONE 2'h1
`define CSK_NOP_TWO 2'h2
`endif

// ==== hdl/csk_pkg.sv ====
// Types shared by the compare-and-skip decoder
package csk_pkg;
  typedef enum logic [1:0] {
    CSK_MODE_ACCESS,
    CSK_MODE_BANKED,
    CSK_MODE_INDEXED
  } csk_mode_type;

  typedef struct packed {
    logic valid;
    csk_pkg::csk_mode_type mode;
    logic [11:0] addr;
  } csk_addr_type;
endpackage : csk_pkg

// ==== hdl/csk_addr_gen.sv ====
// File address generator for the compare-and-skip decoder
`timescale 1ns/1ps
`include "csk_consts.svh"
module csk_addr_gen (
  input wire logic [7:0] file_addr_in,      // f operand
  input wire logic bank_bit_in,             // a operand
  input wire logic [3:0] bank_select_in,    // bank_select_register
  input wire logic ext_en_in,               // effective extended enable
  input wire logic [11:0] index_base_in,    // index pointer for offsets
  output csk_pkg::csk_addr_type addr_out    // resolved address
);
  // ---------------------------------------------------------------
  // Address resolution
  // ---------------------------------------------------------------
  wire logic idx_sel;
  wire logic low_half;
  assign idx_sel = !bank_bit_in && ext_en_in
                   && (file_addr_in <= `CSK_IDX_LIMIT);
  assign low_half = (file_addr_in <= `CSK_ACC_LOW_LIMIT);

  // Indexed wins over access; banked uses the select register
  always_comb
  begin
    addr_out.valid = 1'b1;
    if (bank_bit_in)
    begin
      addr_out.mode = csk_pkg::CSK_MODE_BANKED;
      addr_out.addr = {bank_select_in, file_addr_in};
    end
    else if (idx_sel)
    begin
      addr_out.mode = csk_pkg::CSK_MODE_INDEXED;
      addr_out.addr = index_base_in + {4'h0, file_addr_in};
    end
    else
    begin
      addr_out.mode = csk_pkg::CSK_MODE_ACCESS;
      addr_out.addr = {low_half ? `CSK_ACC_LOW_BANK : `CSK_ACC_HIGH_BANK,
                       file_addr_in};
    end
  end
endmodule : csk_addr_gen

// ==== hdl/csk_decoder.sv ====
// Compare-and-skip instruction decode and execute stage
`timescale 1ns/1ps
`include "csk_consts.svh"
module csk_decoder (
  input wire logic clock_in,                // core instruction clock
  input wire logic rst_b_in,                // async reset, active low
  input wire logic instr_valid_in,          // instruction word valid
  input wire logic [15:0] instr_in,         // instruction word
  input wire logic next_two_word_in,        // fetched next is two-word
  input wire logic [7:0] file_data_in,      // file byte read data
  input wire logic [7:0] working_reg_in,    // working_register value
  input wire logic [3:0] bank_select_in,    // bank_select_register
  input wire logic extended_set_enable_cfg_in, // config bit
  input wire logic [11:0] index_base_in,    // index base pointer
  output logic [11:0] file_addr_out,        // resolved file address
  output logic file_rd_out,                 // file read strobe
  output logic [1:0] addr_mode_out,         // resolved mode
  output logic is_compare_out,              // compare decoded
  output logic skip_out,                    // skip taken pulse
  output logic flush_out,                   // squash fetched word
  output logic stall_out,                   // nop cycle in progress
  output logic write_en_out,                // never writes
  output logic status_we_out                // never touches flags
);
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire logic op_gt;
  wire logic op_lt;
  wire logic is_cmp;
  wire logic ext_en;
  wire logic gt;
  wire logic lt;
  wire logic take;
  wire logic busy;
  csk_pkg::csk_addr_type res;
  logic exec_q;
  logic gt_op_q;
  logic two_q;
  logic [1:0] nop_cnt_q;
  logic [1:0] nop_cnt_d;

  // Opcode match shared by both compare kinds
  function automatic logic match_op(input logic [15:0] word,
    input logic [2:0] sub);
    match_op = (word[15:`CSK_OP_HI_POS] == `CSK_OPC_HI)
      && (word[11:`CSK_SUB_POS] == sub);
  endfunction : match_op

  // Opcode fields of the incoming word
  assign op_gt = match_op(instr_in, `CSK_SUB_GT);
  assign op_lt = match_op(instr_in, `CSK_SUB_LT);
  assign ext_en = extended_set_enable_cfg_in;
  assign is_cmp = instr_valid_in && (op_gt || op_lt) && !busy;

  csk_addr_gen u_addr (
    .file_addr_in(instr_in[7:0]),
    .bank_bit_in(instr_in[`CSK_A_POS]),
    .bank_select_in(bank_select_in),
    .ext_en_in(ext_en),
    .index_base_in(index_base_in),
    .addr_out(res)
  );

  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  // Unsigned compare of file byte and working register, no writeback
  assign gt = file_data_in > working_reg_in;
  assign lt = file_data_in < working_reg_in;
  assign take = exec_q && (gt_op_q ? gt : lt);

  // Exec and nop cycles both refuse new words; nothing is queued
  assign busy = exec_q || (nop_cnt_q != 2'h0);

  // Skip costs one nop, or two when the skipped word is double
  always_comb
  begin
    nop_cnt_d = nop_cnt_q;
    if (take)
      nop_cnt_d = two_q ? `CSK_NOP_TWO
                        : `CSK_NOP_ONE;
    else if (nop_cnt_q != 2'h0)
      nop_cnt_d = nop_cnt_q - 2'h1;
  end

  // ---------------------------------------------------------------
  // Pipeline state
  // ---------------------------------------------------------------
  // Exec flag: high for the one cycle the file byte is read
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      exec_q <= 1'b0;
    else
      exec_q <= is_cmp;
  end

  // Opcode kind and next-word size, latched on every accepted compare word
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      gt_op_q <= 1'b0;
      two_q <= 1'b0;
    end
    else if (is_cmp)
    begin
      gt_op_q <= op_gt;
      two_q <= next_two_word_in;
    end
  end

  // Nop counter; refused words cannot reload it mid-count
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      nop_cnt_q <= 2'h0;
    else
      nop_cnt_q <= nop_cnt_d;
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // Address and mode hold until the next accepted compare word
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      file_addr_out <= 12'h000;
      addr_mode_out <= 2'h0;
    end
    else if (is_cmp)
    begin
      file_addr_out <= res.addr;
      addr_mode_out <= res.mode;
    end
  end

  // Read strobe and decode flag mark the exec cycle
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      file_rd_out <= 1'b0;
      is_compare_out <= 1'b0;
    end
    else
    begin
      file_rd_out <= is_cmp;
      is_compare_out <= is_cmp;
    end
  end

  // Skip and flush pulse together so the fetched word is squashed
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      skip_out <= 1'b0;
      flush_out <= 1'b0;
    end
    else
    begin
      skip_out <= take;
      flush_out <= take;
    end
  end

  // Stall follows the next count, so it leaves a flop in step
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      stall_out <= 1'b0;
    else
      stall_out <= (nop_cnt_d != 2'h0);
  end

  // Held low; the compare never writes back or touches flags
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      write_en_out <= 1'b0;
      status_we_out <= 1'b0;
    end
    else
    begin
      write_en_out <= 1'b0;
      status_we_out <= 1'b0;
    end
  end
endmodule : csk_decoder

// ==== test/csk_decoder_sva.sv ====
// Checker for the compare-and-skip decoder ports
`timescale 1ns/1ps
module csk_chk (
  input wire logic clock_in, rst_b_in, instr_valid_in, next_two_word_in,
  input wire logic [15:0] instr_in,
  input wire logic [7:0] file_data_in, working_reg_in,
  input wire logic [3:0] bank_select_in,
  input wire logic extended_set_enable_cfg_in,
  input wire logic [11:0] index_base_in, file_addr_out,
  input wire logic file_rd_out, is_compare_out, skip_out, flush_out,
  input wire logic stall_out, write_en_out, status_we_out,
  input wire logic [1:0] addr_mode_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Idle decoder takes a compare word; busy cycles are ignored
  wire logic take_w = instr_valid_in && instr_in[15:11] == 5'h0C
    && !instr_in[9] && !file_rd_out && !stall_out;
  wire logic [7:0] f_w = instr_in[7:0];
  logic gt_q, tw_q;
  // Opcode kind and next-word size kept from the taking edge
  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in) {gt_q, tw_q} <= 2'h0;
    else if (take_w) {gt_q, tw_q} <= {instr_in[10], next_two_word_in};
  wire logic cmp_w = gt_q ? file_data_in > working_reg_in
    : file_data_in < working_reg_in;
  a_take_read: assert property (take_w |=> file_rd_out && is_compare_out)
    else $error("compare not read");
  a_skip_cmp: assert property (file_rd_out |=> skip_out == $past(cmp_w))
    else $error("skip decision wrong");
  a_flush_skip: assert property (flush_out == skip_out)
    else $error("flush differs from skip");
  a_stall_len: assert property (skip_out |-> stall_out ##1
    stall_out == tw_q ##1 !stall_out) else $error("nop count wrong");
  a_stall_cause: assert property ($rose(stall_out) |-> skip_out)
    else $error("nop without skip");
  a_banked_addr: assert property (file_rd_out && $past(instr_in[8]) |->
    addr_mode_out == 2'h1 && file_addr_out == $past({bank_select_in, f_w}))
    else $error("banked address wrong");
  a_index_addr: assert property (file_rd_out && $past(!instr_in[8] &&
    extended_set_enable_cfg_in && f_w <= 8'h5F) |-> addr_mode_out == 2'h2
    && file_addr_out == $past(index_base_in + {4'h0, f_w}))
    else $error("indexed address wrong");
  a_ext_off: assert property (file_rd_out && $past(!instr_in[8] &&
    !extended_set_enable_cfg_in) |-> addr_mode_out == 2'h0)
    else $error("access mode wrong");
  a_no_write: assert property (!write_en_out && !status_we_out)
    else $error("compare wrote state");
  c_two_word: cover property (skip_out && tw_q);
  c_indexed: cover property (file_rd_out && addr_mode_out == 2'h2);
  c_no_skip: cover property (file_rd_out ##1 !skip_out);
endmodule : csk_chk
bind csk_decoder csk_chk i_chk (.*);

// ==== test/tb.sv ====
// Random self-checking bench for the compare-and-skip decoder
`timescale 1ns/1ps
module tb;
  logic clock_in = 0, rst_b_in = 0, instr_valid_in = 0;
  logic next_two_word_in = 0, extended_set_enable_cfg_in = 0;
  logic [15:0] instr_in = 16'h0000;
  logic [7:0] file_data_in = 8'h00, working_reg_in = 8'h00;
  logic [3:0] bank_select_in = 4'h0;
  logic [11:0] index_base_in = 12'h000, file_addr_out;
  logic file_rd_out, is_compare_out, skip_out, flush_out, stall_out;
  logic write_en_out, status_we_out;
  logic [1:0] addr_mode_out;
  int failures = 0, checks = 0;
  always #2 clock_in = ~clock_in;
  csk_decoder i_dut (.*);
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // Mode in the top bits; access bank split at 7Fh
  function automatic logic [13:0] exp_addr(logic [7:0] f, logic a, x,
    logic [3:0] b, logic [11:0] ib);
    if (a) return {2'h1, b, f};
    if (x && f <= 8'h5F) return {2'h2, ib + {4'h0, f}};
    return {2'h0, (f <= 8'h7F) ? 4'h0 : 4'hF, f};
  endfunction : exp_addr
  // Equal bytes is the corner that must never skip
  initial
  begin
    logic gt, cmp, sk, tw;
    logic [7:0] d, w;
    logic [13:0] ea;
    int k;
    void'($urandom(53100));
    repeat (12) @(posedge clock_in);
    rst_b_in <= 1;
    for (int i = 0; i < 400; i++)
    begin
      k = $urandom % 8;
      gt = 1'($urandom);
      cmp = k != 7;
      d = (k == 1) ? 8'hFF : 8'($urandom);
      w = (k == 0) ? d : (k == 2) ? 8'h00 : 8'($urandom);
      @(posedge clock_in);
      instr_valid_in <= 1'b1;
      instr_in <= {cmp ? 4'h6 : 4'h5, 1'b0, gt, 1'b0, 9'($urandom)};
      next_two_word_in <= 1'($urandom);
      extended_set_enable_cfg_in <= 1'($urandom);
      bank_select_in <= 4'($urandom);
      index_base_in <= 12'($urandom);
      @(posedge clock_in);
      ea = exp_addr(instr_in[7:0], instr_in[8], extended_set_enable_cfg_in,
        bank_select_in, index_base_in);
      sk = cmp && (gt ? d > w : d < w);
      tw = next_two_word_in;
      // Valid may linger into the exec cycle, where it must be refused
      instr_valid_in <= 1'($urandom);
      file_data_in <= d;
      working_reg_in <= w;
      #1;
      chk("file_rd", 12'(cmp), 12'(file_rd_out));
      chk("is_compare", 12'(cmp), 12'(is_compare_out));
      if (cmp) chk("addr", ea[11:0], file_addr_out);
      if (cmp) chk("mode", 12'(ea[13:12]), 12'(addr_mode_out));
      @(posedge clock_in);
      instr_valid_in <= 1'b0;
      #1;
      chk("refused", 12'h000, 12'(file_rd_out));
      chk("skip", 12'(sk), 12'(skip_out));
      chk("flush", 12'(sk), 12'(flush_out));
      chk("stall", 12'(sk), 12'(stall_out));
      @(posedge clock_in);
      #1;
      chk("stall2", 12'(sk && tw), 12'(stall_out));
      chk("writes", 12'h000, 12'({write_en_out, status_we_out}));
      @(posedge clock_in);
    end
    print_verdict();
  end
  // Run needs about 2000 cycles; cut off well beyond
  initial
  begin
    #40000;
    failures++;
    print_verdict();
  end
endmodule : tb
